// ---- src/rcs_bank.sv ----
// Config/status register bank of a multiphase regulator controller.
// Assumes a byte register port from the serial front end on clk_i; the
// second-function latch bytes come from registers kept elsewhere.
//
// How it works
// - Lock bit makes limit registers read-only
// - Lock holds until power cycle only
// - Enable rise captures soft-start strap code
// - Ramp code selects 0.15 to 10 ms
// - Enable rise captures overcurrent strap code
// - Config rules only when both latches select
// - Limit and delay fields set independently
// - Limit codes 65, 75, 100, 134 mV
// - Delay codes 4, 6, 8, 10 ms
// - Enable rise captures even frequency strap code
// - Frequency config rules when both latches select
// - Frequency depends on code and phase count
// - Power-saving status shows live input level
// - Enable toggle restores strap control
`include "rcs_regs.svh"

module rcs_bank (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        en_pin_i,
  input  wire logic [3:0]  ss_strap_i,
  input  wire logic [3:0]  oc_strap_i,
  input  wire logic [4:0]  fsw_strap_i,
  input  wire logic        psi_low_i,
  input  wire logic        psi_high_i,
  input  wire logic [7:0]  sf_latch_a_i,
  input  wire logic [7:0]  sf_latch_b_i,
  input  wire logic [1:0]  phase_count_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             lock_o,
  output logic             sf_restore_o,
  output logic      [3:0]  ramp_code_o,
  output logic      [9:0]  ramp_time_o,
  output rcs_pkg::rcs_sel2_t oc_limit_sel_o,
  output rcs_pkg::rcs_sel2_t oc_delay_sel_o,
  output logic      [7:0]  oc_limit_mv_o,
  output logic      [3:0]  oc_delay_ms_o,
  output logic      [4:0]  fsw_code_o,
  output logic      [10:0] fsw_khz_o
);

  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [1:0]  en_sync;
  logic        en_prev;
  logic        en_rise;
  logic        en_edge;
  logic [3:0]  ss_s1, ss_s2;
  logic [3:0]  oc_s1, oc_s2;
  logic [4:0]  fsw_s1, fsw_s2;
  logic [1:0]  psi_s1, psi_s2;
  logic        lock;
  logic [3:0]  ss_status;
  logic [3:0]  oc_status;
  logic [3:0]  oc_config;
  logic [4:0]  fsw_status;
  logic [4:0]  fsw_config;
  rcs_pkg::rcs_ps_t ps_state;
  logic        oc_reg_sel;
  logic        fsw_reg_sel;
  logic        wr_lock, wr_oc, wr_fsw;
  logic [7:0]  next_rdata;

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      en_sync <= 2'h0;
      ss_s1   <= 4'h0;
      ss_s2   <= 4'h0;
      oc_s1   <= 4'h0;
      oc_s2   <= 4'h0;
      fsw_s1  <= 5'h00;
      fsw_s2  <= 5'h00;
      psi_s1  <= 2'h0;
      psi_s2  <= 2'h0;
    end else begin
      en_sync <= {en_sync[0], en_pin_i};
      ss_s1   <= ss_strap_i;
      ss_s2   <= ss_s1;
      oc_s1   <= oc_strap_i;
      oc_s2   <= oc_s1;
      fsw_s1  <= fsw_strap_i;
      fsw_s2  <= fsw_s1;
      psi_s1  <= {psi_high_i, psi_low_i};
      psi_s2  <= psi_s1;
    end
  end

  // Enable edge detection on the synchronised copy
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      en_prev <= 1'b0;
    end else begin
      en_prev <= en_sync[1];
    end
  end
  assign en_rise = en_sync[1] & ~en_prev;
  assign en_edge = en_sync[1] ^ en_prev;

  // Write decode; limit registers refuse writes once locked
  assign wr_lock = reg_wr_i && (reg_addr_i == `RCS_OFF_WRITE_LOCK);
  assign wr_oc   = reg_wr_i && (reg_addr_i == `RCS_OFF_OC_CONFIG) && !lock;
  assign wr_fsw  = reg_wr_i && (reg_addr_i == `RCS_OFF_FSW_CONFIG) && !lock;

  // Lock is sticky; only power-on reset clears it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lock <= `RCS_RST_LOCK;
    end else if (wr_lock && reg_wdata_i[`RCS_LOCK_BIT]) begin
      lock <= 1'b1;
    end
  end

  // Strap codes captured on each enable rise
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ss_status  <= 4'h0;
      oc_status  <= 4'h0;
      fsw_status <= 5'h00;
    end else if (en_rise) begin
      ss_status  <= ss_s2;
      oc_status  <= oc_s2;
      fsw_status <= {fsw_s2[4:1], 1'b0};
    end
  end

  // Configuration registers, fields written independently of strap pairing
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      oc_config  <= 4'h0;
      fsw_config <= 5'h00;
    end else begin
      if (wr_oc) begin
        oc_config <= reg_wdata_i[3:0];
      end
      if (wr_fsw) begin
        fsw_config <= reg_wdata_i[4:0];
      end
    end
  end

  // Live power-saving level; both levels at once report middle
  always_comb begin
    case (psi_s2)
      2'b01:   ps_state = rcs_pkg::RCS_PS_LOW;
      2'b10:   ps_state = rcs_pkg::RCS_PS_HIGH;
      default: ps_state = rcs_pkg::RCS_PS_MID;
    endcase
  end

  // Register control needs the select bit in both latch bytes
  assign oc_reg_sel  = sf_latch_a_i[`RCS_SEL_OC_BIT] & sf_latch_b_i[`RCS_SEL_OC_BIT];
  assign fsw_reg_sel = sf_latch_a_i[`RCS_SEL_FSW_BIT] & sf_latch_b_i[`RCS_SEL_FSW_BIT];

  // Effective settings from strap or configuration
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      oc_limit_sel_o <= 2'h0;
      oc_delay_sel_o <= 2'h0;
      fsw_code_o     <= 5'h00;
      ramp_code_o    <= 4'h0;
    end else begin
      oc_limit_sel_o <= oc_reg_sel ? oc_config[3:2] : oc_status[3:2];
      oc_delay_sel_o <= oc_reg_sel ? oc_config[1:0] : oc_status[1:0];
      fsw_code_o     <= fsw_reg_sel ? fsw_config : fsw_status;
      ramp_code_o    <= ss_status;
    end
  end

  // Decoded limit, delay and ramp time (10 us units)
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      oc_limit_mv_o <= 8'h00;
      oc_delay_ms_o <= 4'h0;
      ramp_time_o   <= 10'h000;
    end else begin
      case (oc_limit_sel_o)
        2'b00:   oc_limit_mv_o <= 8'h41;
        2'b01:   oc_limit_mv_o <= 8'h4b;
        2'b10:   oc_limit_mv_o <= 8'h64;
        default: oc_limit_mv_o <= 8'h86;
      endcase
      case (oc_delay_sel_o)
        2'b00:   oc_delay_ms_o <= 4'h4;
        2'b01:   oc_delay_ms_o <= 4'h6;
        2'b10:   oc_delay_ms_o <= 4'h8;
        default: oc_delay_ms_o <= 4'ha;
      endcase
      if (ramp_code_o < 4'h6) begin
        ramp_time_o <= 10'(({6'h00, ramp_code_o} + 10'h001) * 10'h00f);
      end else if (ramp_code_o == 4'h6) begin
        ramp_time_o <= 10'h064;
      end else begin
        ramp_time_o <= 10'(({6'h00, ramp_code_o} - 10'h005) * 10'h064);
      end
    end
  end

  // Frequency from code and active phase count
  rcs_fsw_lut u_fsw_lut (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n),
    .code_i        (fsw_code_o),
    .phase_count_i (phase_count_i),
    .khz_o         (fsw_khz_o)
  );

  // Lock output and strap-control restore pulse on any enable toggle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lock_o       <= 1'b0;
      sf_restore_o <= 1'b0;
    end else begin
      lock_o       <= lock;
      sf_restore_o <= en_edge;
    end
  end

  // Read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    case (reg_addr_i)
      `RCS_OFF_WRITE_LOCK:      next_rdata = {7'h00, lock};
      `RCS_OFF_SOFT_START_STAT: next_rdata = {4'h0, ss_status};
      `RCS_OFF_OC_STATUS:       next_rdata = {4'h0, oc_status};
      `RCS_OFF_OC_CONFIG:       next_rdata = {4'h0, oc_config};
      `RCS_OFF_FSW_STATUS:      next_rdata = {3'h0, fsw_status};
      `RCS_OFF_FSW_CONFIG:      next_rdata = {3'h0, fsw_config};
      `RCS_OFF_PS_STATUS:       next_rdata = {6'h00, ps_state};
      default:                  next_rdata = `RCS_RST_BYTE;
    endcase
  end

  // Read data registered, held until the next read
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= `RCS_RST_BYTE;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  AST_LOCK_SET: assert property (
    wr_lock && reg_wdata_i[0] |=> lock ##1 lock_o)
    else $error("lock not set by write");

  AST_LOCK_STICKY: assert property (
    lock |=> lock [*8])
    else $error("lock released");

  AST_OC_CFG_LOCKED: assert property (
    lock && reg_wr_i && reg_addr_i == 8'h2e |=> $stable(oc_config))
    else $error("locked config changed");

  AST_SS_CAPTURE: assert property (
    en_rise |=> ss_status == $past(ss_s2) ##1 ramp_code_o == $past(ss_status))
    else $error("soft start code not captured");

  AST_RAMP_ENDS: assert property (
    ramp_code_o == 4'hf |=> ramp_time_o == 10'h3e8)
    else $error("ramp time wrong");

  AST_OC_STRAP: assert property (
    en_rise |=> oc_status == $past(oc_s2))
    else $error("overcurrent code not captured");

  AST_OC_SOURCE: assert property (
    oc_reg_sel |=> oc_limit_sel_o == $past(oc_config[3:2])
               && oc_delay_sel_o == $past(oc_config[1:0]))
    else $error("overcurrent source wrong");

  AST_OC_INDEP: assert property (
    wr_oc |=> oc_config == $past(reg_wdata_i[3:0]))
    else $error("config fields not written");

  AST_OC_MV: assert property (
    oc_limit_sel_o == 2'b11 |=> oc_limit_mv_o == 8'h86)
    else $error("limit decode wrong");

  AST_OC_DELAY: assert property (
    oc_delay_sel_o == 2'b00 |=> oc_delay_ms_o == 4'h4)
    else $error("delay decode wrong");

  AST_FSW_EVEN: assert property (
    en_rise |=> fsw_status == {$past(fsw_s2[4:1]), 1'b0})
    else $error("frequency strap not even");

  AST_FSW_SOURCE: assert property (
    !fsw_reg_sel |=> fsw_code_o == $past(fsw_status))
    else $error("frequency source wrong");

  AST_FSW_KHZ: assert property (
    fsw_code_o == 5'h1f && phase_count_i == 2'b11 |=> fsw_khz_o == 11'd1312)
    else $error("frequency lookup wrong");

  AST_PS_READ: assert property (
    reg_rd_i && reg_addr_i == 8'h32 |=>
      reg_rdata_o[7:2] == 6'h00 && reg_rdata_o[1:0] != 2'b11)
    else $error("power-saving status bad");

  AST_RESTORE: assert property (
    en_edge |=> sf_restore_o)
    else $error("restore pulse missing");

  COV_LOCK: cover property (wr_lock && reg_wdata_i[0] ##1 reg_wr_i && reg_addr_i == 8'h2e);
  COV_EN_RISE: cover property (en_rise ##2 reg_rd_i && reg_addr_i == 8'h2b);
  COV_OC_REG: cover property (oc_reg_sel && wr_oc);
  COV_FSW_REG: cover property (fsw_reg_sel && fsw_code_o == 5'h1f);

endmodule

// ---- src/rcs_fsw_lut.sv ----
// Switching-frequency lookup: 5-bit code and phase count to kHz.
// Assumes code and phase count are synchronous to clk_i.
module rcs_fsw_lut (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [4:0]  code_i,
  input  wire logic [1:0]  phase_count_i,
  output logic      [10:0] khz_o
);

  logic [43:0] row;

  // One row per code: 4, 3, 2 and 1 phase frequencies
  always_comb begin
    case (code_i)
      5'h00: row = {11'd221,  11'd293,  11'd223,  11'd232};
      5'h01: row = {11'd244,  11'd329,  11'd243,  11'd252};
      5'h02: row = {11'd266,  11'd358,  11'd264,  11'd272};
      5'h03: row = {11'd293,  11'd381,  11'd294,  11'd297};
      5'h04: row = {11'd307,  11'd407,  11'd317,  11'd322};
      5'h05: row = {11'd333,  11'd450,  11'd335,  11'd340};
      5'h06: row = {11'd351,  11'd480,  11'd352,  11'd361};
      5'h07: row = {11'd373,  11'd510,  11'd380,  11'd385};
      5'h08: row = {11'd394,  11'd530,  11'd399,  11'd413};
      5'h09: row = {11'd421,  11'd562,  11'd420,  11'd435};
      5'h0a: row = {11'd449,  11'd600,  11'd436,  11'd456};
      5'h0b: row = {11'd469,  11'd614,  11'd454,  11'd478};
      5'h0c: row = {11'd479,  11'd631,  11'd483,  11'd500};
      5'h0d: row = {11'd509,  11'd663,  11'd508,  11'd509};
      5'h0e: row = {11'd518,  11'd688,  11'd526,  11'd518};
      5'h0f: row = {11'd543,  11'd722,  11'd543,  11'd540};
      5'h10: row = {11'd581,  11'd789,  11'd583,  11'd578};
      5'h11: row = {11'd649,  11'd859,  11'd656,  11'd638};
      5'h12: row = {11'd708,  11'd930,  11'd698,  11'd698};
      5'h13: row = {11'd751,  11'd1010, 11'd771,  11'd758};
      5'h14: row = {11'd799,  11'd1095, 11'd807,  11'd818};
      5'h15: row = {11'd866,  11'd1147, 11'd860,  11'd878};
      5'h16: row = {11'd919,  11'd1233, 11'd899,  11'd938};
      5'h17: row = {11'd964,  11'd1260, 11'd950,  11'd972};
      5'h18: row = {11'd993,  11'd1341, 11'd1003, 11'd1014};
      5'h19: row = {11'd1059, 11'd1372, 11'd1052, 11'd1067};
      5'h1a: row = {11'd1098, 11'd1450, 11'd1096, 11'd1106};
      5'h1b: row = {11'd1141, 11'd1539, 11'd1154, 11'd1155};
      5'h1c: row = {11'd1200, 11'd1619, 11'd1205, 11'd1201};
      5'h1d: row = {11'd1236, 11'd1618, 11'd1227, 11'd1245};
      5'h1e: row = {11'd1291, 11'd1674, 11'd1274, 11'd1280};
      default: row = {11'd1312, 11'd1724, 11'd1316, 11'd1330};
    endcase
  end

  // Pick the column for the active phase count (count minus one)
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      khz_o <= 11'h000;
    end else begin
      case (phase_count_i)
        2'b11:   khz_o <= row[43:33];
        2'b10:   khz_o <= row[32:22];
        2'b01:   khz_o <= row[21:11];
        default: khz_o <= row[10:0];
      endcase
    end
  end

endmodule

// ---- src/rcs_pkg.sv ----
// Types shared by the regulator config/status bank.
// Assumes nothing beyond a SystemVerilog compiler.
package rcs_pkg;

  // Decoded state of the three-level power-saving input
  typedef enum logic [1:0] {
    RCS_PS_MID  = 2'b00,
    RCS_PS_LOW  = 2'b01,
    RCS_PS_HIGH = 2'b10
  } rcs_ps_t;

  // Two-bit selector for the current limit and the delay
  typedef logic [1:0] rcs_sel2_t;

endpackage

// ---- src/rcs_regs.svh ----
// Offsets, field positions, reset values and timing counts of the config/status bank.
// Assumes a byte-wide register port behind the device's serial front end.
`ifndef RCS_REGS_SVH
`define RCS_REGS_SVH

// Register offsets
`define RCS_OFF_WRITE_LOCK       8'h2a
`define RCS_OFF_SOFT_START_STAT  8'h2b
`define RCS_OFF_OC_STATUS        8'h2d
`define RCS_OFF_OC_CONFIG        8'h2e
`define RCS_OFF_FSW_STATUS       8'h2f
`define RCS_OFF_FSW_CONFIG       8'h30
`define RCS_OFF_PS_STATUS        8'h32

// Field positions
`define RCS_LOCK_BIT             0
`define RCS_SEL_OC_BIT           2
`define RCS_SEL_FSW_BIT          5

// Reset values
`define RCS_RST_BYTE             8'h00
`define RCS_RST_LOCK             1'b0

// Clock and synchroniser depth
`define RCS_CLK_PERIOD_NS        20
`define RCS_SYNC_STAGES          2

`endif

// ---- verif/rcs_bank_test.sv ----
// Self-checking bench of the regulator config/status bank.
// Assumes the bank and the latch model alone; reads are checked from a queue.
module rcs_bank_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0, resetn_i = 1'b0, en_pin_i = 1'b0;
  logic [3:0] ss_strap_i = 4'h0, oc_strap_i = 4'h0;
  logic [4:0] fsw_strap_i = 5'h00;
  logic psi_low_i = 1'b0, psi_high_i = 1'b0;
  logic [1:0] phase_count_i = 2'h3;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, lat_wdata = 8'h00;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, lat_wr_a = 1'b0, lat_wr_b = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] sf_latch_a_i, sf_latch_b_i, reg_rdata_o, oc_limit_mv_o;
  logic lock_o, sf_restore_o;
  logic [3:0] ramp_code_o, oc_delay_ms_o;
  logic [9:0] ramp_time_o;
  rcs_pkg::rcs_sel2_t oc_limit_sel_o, oc_delay_sel_o;
  logic [4:0] fsw_code_o;
  logic [10:0] fsw_khz_o;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'hba5bdfc7;
  int err_count = 0, checked = 0;
  localparam int RT[16] = '{15, 30, 45, 60, 75, 90, 100, 200, 300, 400, 500, 600, 700,
                            800, 900, 1000};
  localparam int MV[4] = '{65, 75, 100, 134};
  localparam int MS[4] = '{4, 6, 8, 10};
  localparam logic [1:0] PH[5] = '{2'h3, 2'h2, 2'h1, 2'h3, 2'h0};
  localparam int KHZ[5] = '{1312, 1724, 1316, 221, 232};
  int restores = 0;

  always #10 clk_i = ~clk_i;

  rcs_bank i_rcs_bank (.clk_i(clk_i), .resetn_i(resetn_i), .en_pin_i(en_pin_i),
    .ss_strap_i(ss_strap_i), .oc_strap_i(oc_strap_i), .fsw_strap_i(fsw_strap_i),
    .psi_low_i(psi_low_i), .psi_high_i(psi_high_i), .sf_latch_a_i(sf_latch_a_i),
    .sf_latch_b_i(sf_latch_b_i), .phase_count_i(phase_count_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .lock_o(lock_o), .sf_restore_o(sf_restore_o),
    .ramp_code_o(ramp_code_o), .ramp_time_o(ramp_time_o), .oc_limit_sel_o(oc_limit_sel_o),
    .oc_delay_sel_o(oc_delay_sel_o), .oc_limit_mv_o(oc_limit_mv_o),
    .oc_delay_ms_o(oc_delay_ms_o), .fsw_code_o(fsw_code_o), .fsw_khz_o(fsw_khz_o));

  rcs_latch_model i_rcs_latch_model (.clk_i(clk_i), .resetn_i(resetn_i), .wr_a_i(lat_wr_a),
    .wr_b_i(lat_wr_b), .wdata_i(lat_wdata), .sf_restore_i(sf_restore_o),
    .latch_a_o(sf_latch_a_i), .latch_b_o(sf_latch_b_i));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick(1);
    reg_rd_i = 1'b0;
    tick(1);
  endtask

  // Host side of the latch pair; a and b select which bytes are written
  task automatic latch(input logic a, input logic b, input logic [7:0] d);
    lat_wdata = d;
    lat_wr_a = a;
    lat_wr_b = b;
    tick(1);
    lat_wr_a = 1'b0;
    lat_wr_b = 1'b0;
    tick(4);
  endtask

  task automatic en_toggle();
    en_pin_i = 1'b0;
    tick(8);
    en_pin_i = 1'b1;
    tick(8);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Read answers land one cycle after the read edge; restore pulses are counted
  always @(posedge clk_i) begin
    if (rd_q) begin
      check({8'h00, reg_rdata_o}, {8'h00, exp_q.pop_front()});
    end
    if (sf_restore_o) begin
      restores++;
    end
    rd_q <= reg_rd_i;
  end

  // Watchdog
  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end

  initial begin
    logic [31:0] r;
    logic [7:0] c;
    int n;
    tick(4);
    resetn_i = 1'b1;
    tick(4);
    rd(8'h2a, 8'h00);
    rd(8'h2e, 8'h00);
    rd(8'h30, 8'h00);
    // Strap capture on each enable rise
    for (int t = 0; t < 5; t++) begin
      r = xs();
      ss_strap_i = r[3:0];
      oc_strap_i = r[7:4];
      fsw_strap_i = r[12:8];
      phase_count_i = r[14:13];
      en_toggle();
      rd(8'h2b, {4'h0, r[3:0]});
      rd(8'h2d, {4'h0, r[7:4]});
      rd(8'h2f, {3'h0, r[12:9], 1'b0});
      check(16'(ramp_code_o), 16'(r[3:0]));
      check(16'(ramp_time_o), 16'(RT[r[3:0]]));
      check(16'(oc_limit_mv_o), 16'(MV[r[7:6]]));
      check(16'(oc_delay_ms_o), 16'(MS[r[5:4]]));
      check(16'(fsw_code_o), 16'({r[12:9], 1'b0}));
    end
    wr(8'h2b, 8'hff);
    rd(8'h2b, {4'h0, ss_strap_i});
    // One latch alone keeps strap control
    wr(8'h2e, 8'hf9);
    rd(8'h2e, 8'h09);
    latch(1'b1, 1'b0, 8'h24);
    check(16'({oc_limit_sel_o, oc_delay_sel_o}), 16'(oc_strap_i));
    latch(1'b0, 1'b1, 8'h24);
    for (int i = 0; i < 16; i++) begin
      c = 8'(i);
      r = xs();
      wr(8'h2e, {r[3:0], c[3:0]});
      tick(3);
      check(16'(oc_limit_sel_o), 16'(c[3:2]));
      check(16'(oc_delay_sel_o), 16'(c[1:0]));
      check(16'(oc_limit_mv_o), 16'(MV[c[3:2]]));
      check(16'(oc_delay_ms_o), 16'(MS[c[1:0]]));
    end
    // Frequency config codes and phase counts
    for (int i = 0; i < 5; i++) begin
      phase_count_i = PH[i];
      c = (i < 3) ? 8'h1f : 8'h00;
      wr(8'h30, c | 8'he0);
      tick(4);
      rd(8'h30, c);
      check(16'(fsw_code_o), 16'(c));
      check(16'(fsw_khz_o), 16'(KHZ[i]));
    end
    n = restores;
    en_toggle();
    check(16'(restores - n), 16'h0002);
    check(16'({oc_limit_sel_o, oc_delay_sel_o}), 16'(oc_strap_i));
    check(16'(fsw_code_o), 16'({fsw_strap_i[4:1], 1'b0}));
    // Power-saving input levels, both high reads as middle
    for (int i = 0; i < 4; i++) begin
      {psi_high_i, psi_low_i} = 2'(i);
      tick(4);
      rd(8'h32, (i == 3) ? 8'h00 : 8'(i));
    end
    // Lock holds through writes and enable toggles
    wr(8'h2e, 8'h06);
    wr(8'h2a, 8'hff);
    rd(8'h2a, 8'h01);
    check(16'(lock_o), 16'h0001);
    wr(8'h2e, 8'h0b);
    rd(8'h2e, 8'h06);
    wr(8'h2a, 8'h00);
    en_toggle();
    rd(8'h2a, 8'h01);
    wr(8'h30, 8'h05);
    rd(8'h30, 8'h00);
    rd(8'h2c, 8'h00);
    // Power cycle is the only way out of the lock
    resetn_i = 1'b0;
    tick(2);
    resetn_i = 1'b1;
    tick(4);
    rd(8'h2a, 8'h00);
    check(16'(lock_o), 16'h0000);
    tick(4);
    report_and_stop();
  end
endmodule

// ---- verif/rcs_latch_model.sv ----
// Model of the two second-function latch bytes kept outside the bank.
// Assumes the host writes them through strobes on clk_i and that the bank
// asks for strap control with its one-cycle restore pulse.
module rcs_latch_model (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       wr_a_i,
  input  wire logic       wr_b_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       sf_restore_i,
  output logic      [7:0] latch_a_o,
  output logic      [7:0] latch_b_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Latch A: restore wins so strap control comes back on every enable edge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_a_o <= 8'h00;
    end else if (sf_restore_i) begin
      latch_a_o <= 8'h00;
    end else if (wr_a_i) begin
      latch_a_o <= wdata_i & 8'h37; // Reserved bits stay clear
    end
  end

  // Latch B: same behaviour, written on its own strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_b_o <= 8'h00;
    end else if (sf_restore_i) begin
      latch_b_o <= 8'h00;
    end else if (wr_b_i) begin
      latch_b_o <= wdata_i & 8'h37;
    end
  end
endmodule
